// ==== rtl/pic_pkg.sv ====
// Package of constants and carrier types for the interrupt-controller host driver
package pic_pkg;

  // Software register byte offsets
  localparam logic [4:0] REG_CMD = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_INIT = 5'h08;
  localparam logic [4:0] REG_MASK = 5'h0C;
  localparam logic [4:0] REG_RESULT = 5'h10;

  // Command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_LVL_LSB = 4;

  // Init register fields
  localparam int INIT_BASE_LSB = 0;
  localparam int INIT_LEVEL_TRIG_BIT = 8;
  localparam int INIT_INTERVAL4_BIT = 9;
  localparam int INIT_SINGLE_BIT = 10;
  localparam int INIT_WORD4_BIT = 11;
  localparam int INIT_W3_LSB = 12;
  localparam int INIT_W4_LSB = 20;

  // Reset values of software registers
  localparam logic [24:0] INIT_RESET = 25'h000_0000;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // Device word layouts
  localparam logic [7:0] W1_MARK = 8'h10;
  localparam logic [7:0] W3_MARK = 8'h08;
  localparam int W2_ROT_BIT = 7;
  localparam int W2_SPEC_BIT = 6;
  localparam int W2_EOI_BIT = 5;
  localparam int W3_SPMEN_BIT = 6;
  localparam int W3_SPM_BIT = 5;
  localparam int W3_POLL_BIT = 2;
  localparam int W3_RDEN_BIT = 1;
  localparam int W3_RSEL_BIT = 0;
  localparam int POLL_ANY_BIT = 7;

  // Bus timing, in ns, and derived clock counts
  localparam int CLK_NS = 100;
  localparam int T_SETUP_NS = 100;
  localparam int T_STROBE_NS = 400;
  localparam int T_HOLD_NS = 100;
  localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] STROBE_CYC = 4'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] HOLD_CYC = 4'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);

  // Host command codes
  typedef enum logic [3:0] {
    OP_INIT = 4'h0, OP_MASK_WR = 4'h1, OP_EOI = 4'h2, OP_EOI_SPEC = 4'h3,
    OP_ROT_EOI = 4'h4, OP_ROT_SPEC = 4'h5, OP_SET_PRIO = 4'h6, OP_AROT_ON = 4'h7,
    OP_AROT_OFF = 4'h8, OP_SPM_SET = 4'h9, OP_SPM_CLR = 4'hA, OP_POLL = 4'hB,
    OP_RD_REQ = 4'hC, OP_RD_INSVC = 4'hD, OP_RD_MASK = 4'hE, OP_NONE = 4'hF
  } pic_op_t;

  // One device bus access
  typedef struct packed {
    logic rd;
    logic cmd_sel;
    logic [7:0] data;
  } pic_step_t;

  // Pins toward the device
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic command_select_line;
    logic [7:0] data_o;
    logic data_oe;
  } pic_pins_t;

endpackage

// ==== rtl/pic_sync.sv ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pic_sync #(
  parameter int WIDTH = 9
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Asynchronous in, synchronised out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff; // First stage, read only by the second
  logic [WIDTH-1:0] sync_ff; // Second stage
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  // Shift one stage per enabled clock
  always_comb begin
    nxt_meta = ce ? async_in : meta_ff;
    nxt_sync = ce ? meta_ff : sync_ff;
  end

  // Register both stages
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;
endmodule
`default_nettype wire

// ==== rtl/pic_cycle.sv ====
// One strobed read or write cycle on the device bus
`timescale 1ns/1ps
`default_nettype none
module pic_cycle (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Request side
  input wire logic start,
  input wire pic_pkg::pic_step_t step,
  output logic done,
  output logic [7:0] rdata,
  // Device side
  input wire logic [7:0] data_sync,
  output pic_pkg::pic_pins_t pins
);
  import pic_pkg::*;

  typedef enum logic [1:0] {
    CY_IDLE = 2'b00, CY_SETUP = 2'b01, CY_STROBE = 2'b11, CY_HOLD = 2'b10
  } pic_cy_t;

  pic_cy_t st_ff, nxt_st;
  logic [3:0] cnt_ff, nxt_cnt; // Cycles left in the phase
  pic_step_t step_ff, nxt_step; // Access held for the whole cycle
  logic [7:0] rdata_ff, nxt_rdata;
  logic done_ff, nxt_done;

  // Phase sequencing; read data taken on the last strobe cycle, so the
  // strobe must outlast the two-flop input delay
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_step = step_ff;
    nxt_rdata = rdata_ff;
    nxt_done = 1'b0;
    case (st_ff)
      CY_IDLE: begin
        if (start) begin
          nxt_step = step;
          nxt_cnt = SETUP_CYC;
          nxt_st = CY_SETUP;
        end
      end
      CY_SETUP: begin
        nxt_cnt = cnt_ff - 4'h1;
        if (cnt_ff == 4'h1) begin
          nxt_cnt = STROBE_CYC;
          nxt_st = CY_STROBE;
        end
      end
      CY_STROBE: begin
        nxt_cnt = cnt_ff - 4'h1;
        if (cnt_ff == 4'h1) begin
          if (step_ff.rd) begin
            nxt_rdata = data_sync;
          end
          nxt_cnt = HOLD_CYC;
          nxt_st = CY_HOLD;
        end
      end
      CY_HOLD: begin
        nxt_cnt = cnt_ff - 4'h1;
        if (cnt_ff == 4'h1) begin
          nxt_done = 1'b1;
          nxt_st = CY_IDLE;
        end
      end
      default: nxt_st = CY_IDLE;
    endcase
  end

  // State registers, frozen while ce is low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= CY_IDLE;
      cnt_ff <= 4'h0;
      step_ff <= '0;
      rdata_ff <= 8'h00;
      done_ff <= 1'b0;
    end else if (ce) begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      step_ff <= nxt_step;
      rdata_ff <= nxt_rdata;
      done_ff <= nxt_done;
    end
  end

  // Pins follow the phase; data driven only on writes
  always_comb begin
    pins.cs_n = (st_ff == CY_IDLE);
    pins.rd_n = !((st_ff == CY_STROBE) && step_ff.rd);
    pins.wr_n = !((st_ff == CY_STROBE) && !step_ff.rd);
    pins.command_select_line = step_ff.cmd_sel;
    pins.data_o = step_ff.data;
    pins.data_oe = (st_ff != CY_IDLE) && !step_ff.rd;
  end

  assign done = done_ff && ce;
  assign rdata = rdata_ff;
endmodule
`default_nettype wire

// ==== rtl/pic_host.sv ====
// Host driver that programs and polls an eight-level priority interrupt controller
// How it works
// R01: Specific END_OF_INTERRUPT_BIT sets both bits plus level
// R02: Mask bit one blocks that request line
// R03: Special mask stays set until reset command
// R04: Special mask leaves higher levels unchanged
// R05: Poll bit write makes next read acknowledge
// R06: Poll read services highest pending level
// R07: Fresh poll command precedes every poll read
// R08: Poll byte: bit7 pending, bits2-0 level
// R09: Request register ignores mask, clears on acknowledge
// R10: Read request: write read-enable, select zero
// R11: Read in-service: write read-enable, select one
// R12: Line-high read returns mask, no select
// R13: One select serves all later status reads
// R14: Poll plus read-enable returns poll result
// R15: END_OF_INTERRUPT_BIT clears proper in-service bit
// R16: Word two codes rotate, specific, END_OF_INTERRUPT_BIT
// R17: Rotate specific without END_OF_INTERRUPT_BIT sets bottom
// R18: Bit seven alone enables auto-END_OF_INTERRUPT_BIT rotation
// R19: Line-high write loads mask register
// R20: Word three special mask enable/set coding
// R21: Word three read-enable/select coding
// R22: Init word one trigger, interval, single, four
// R23: Vector byte layout per interval
// R24: Init word four mode bit layout
// R25: Slave identity equals master input number
// R26: Processor interrupts held off while commanding
// R27: Empty poll returns bit7 zero only
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module pic_host (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Software register port
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Device pins
  output pic_pkg::pic_pins_t dev_pins,
  input wire logic [7:0] dev_data_i,
  input wire logic dev_int,
  // Processor interrupt hold-off
  output logic cpu_int_block
);
  import pic_pkg::*;

  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00, SQ_ISSUE = 2'b01, SQ_WAIT = 2'b11, SQ_NEXT = 2'b10
  } pic_sq_t;

  // Sequencer state
  pic_sq_t sq_ff, nxt_sq;
  pic_step_t steps_ff [4]; // Queued bus accesses of one command
  pic_step_t nxt_steps [4];
  logic [2:0] num_ff, nxt_num; // Accesses queued
  logic [1:0] idx_ff, nxt_idx; // Access in progress
  // Software-visible state, plus the select and poll flags kept for the sequencer
  logic [24:0] init_ff, nxt_init;
  logic [7:0] mask_ff, nxt_mask;
  logic [7:0] result_ff, nxt_result;
  logic inited_ff, nxt_inited; // Init sequence sent
  logic spmask_ff, nxt_spmask; // Host copy of special mask mode
  logic sel_ok_ff, nxt_sel_ok; // Device status select known
  logic sel_isr_ff, nxt_sel_isr; // Known select points at in-service
  logic is_poll_ff, nxt_is_poll; // Current command is a poll
  logic poll_hit_ff, nxt_poll_hit;
  logic [31:0] rdata_ff, nxt_rdata;

  // Engine and synchroniser links
  logic cy_start;
  logic cy_done;
  logic [7:0] cy_rdata;
  logic [8:0] pin_sync;

  // Pin inputs pass two flops before use
  pic_sync #(.WIDTH(9)) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .async_in({dev_int, dev_data_i}),
    .sync_out(pin_sync)
  );

  // Bus cycle engine
  pic_cycle u_cycle (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .start(cy_start),
    .step(steps_ff[idx_ff]),
    .done(cy_done),
    .rdata(cy_rdata),
    .data_sync(pin_sync[7:0]),
    .pins(dev_pins)
  );

  // Command decode and sequencing
  always_comb begin
    logic [3:0] op;
    logic [2:0] lvl;
    logic [2:0] n;
    logic take;
    op = reg_wdata[CMD_OP_LSB +: 4];
    lvl = reg_wdata[CMD_LVL_LSB +: 3];
    n = 3'd0;
    take = reg_wr && (reg_addr == REG_CMD) && (sq_ff == SQ_IDLE);
    nxt_sq = sq_ff;
    nxt_steps = steps_ff;
    nxt_num = num_ff;
    nxt_idx = idx_ff;
    nxt_init = init_ff;
    nxt_mask = mask_ff;
    nxt_result = result_ff;
    nxt_inited = inited_ff;
    nxt_spmask = spmask_ff;
    nxt_sel_ok = sel_ok_ff;
    nxt_sel_isr = sel_isr_ff;
    nxt_is_poll = is_poll_ff;
    nxt_poll_hit = poll_hit_ff;
    cy_start = 1'b0;
    // Configuration writes
    if (reg_wr && reg_addr == REG_INIT) begin
      nxt_init = reg_wdata[24:0];
    end
    if (reg_wr && reg_addr == REG_MASK) begin
      nxt_mask = reg_wdata[7:0];
    end
    // Commands are taken only while idle; others are dropped
    if (take) begin
      nxt_is_poll = 1'b0;
      case (op)
        OP_INIT: begin
          // Word one: vector bits, mark, trigger, interval, single, word four
          nxt_steps[0] = {1'b0, 1'b0, init_ff[7:5], 1'b1, init_ff[INIT_LEVEL_TRIG_BIT],
            init_ff[INIT_INTERVAL4_BIT], init_ff[INIT_SINGLE_BIT], init_ff[INIT_WORD4_BIT]}; // R22
          nxt_steps[1] = {1'b0, 1'b1, init_ff[INIT_BASE_LSB +: 8]}; // R23
          n = 3'd2;
          if (!init_ff[INIT_SINGLE_BIT]) begin
            nxt_steps[n[1:0]] = {1'b0, 1'b1, init_ff[INIT_W3_LSB +: 8]}; // R25
            n = n + 3'd1;
          end
          if (init_ff[INIT_WORD4_BIT]) begin
            nxt_steps[n[1:0]] = {1'b0, 1'b1, 3'b000, init_ff[INIT_W4_LSB +: 5]}; // R24
            n = n + 3'd1;
          end
          nxt_inited = 1'b1;
          nxt_spmask = 1'b0;
          nxt_sel_ok = 1'b0;
        end
        OP_MASK_WR: begin
          nxt_steps[0] = {1'b0, 1'b1, mask_ff}; // R19
          n = 3'd1;
        end
        OP_EOI: begin
          nxt_steps[0] = {1'b0, 1'b0, 8'h20}; // R16
          n = 3'd1;
        end
        OP_EOI_SPEC: begin
          nxt_steps[0] = {1'b0, 1'b0, 3'b011, 2'b00, lvl}; // R01
          n = 3'd1;
        end
        OP_ROT_EOI: begin
          nxt_steps[0] = {1'b0, 1'b0, 8'hA0}; // R16
          n = 3'd1;
        end
        OP_ROT_SPEC: begin
          nxt_steps[0] = {1'b0, 1'b0, 3'b111, 2'b00, lvl}; // R01
          n = 3'd1;
        end
        OP_SET_PRIO: begin
          nxt_steps[0] = {1'b0, 1'b0, 3'b110, 2'b00, lvl}; // R17
          n = 3'd1;
        end
        OP_AROT_ON: begin
          nxt_steps[0] = {1'b0, 1'b0, 8'h80}; // R18
          n = 3'd1;
        end
        OP_AROT_OFF: begin
          nxt_steps[0] = {1'b0, 1'b0, 8'h00}; // R18
          n = 3'd1;
        end
        OP_SPM_SET, OP_SPM_CLR: begin
          nxt_steps[0] = {1'b0, 1'b0, W3_MARK};
          nxt_steps[0].data[W3_SPMEN_BIT] = 1'b1; // R20
          nxt_steps[0].data[W3_SPM_BIT] = (op == OP_SPM_SET);
          nxt_spmask = (op == OP_SPM_SET); // R03
          n = 3'd1;
        end
        OP_POLL: begin
          // Always a fresh poll word, then exactly one read
          nxt_steps[0] = {1'b0, 1'b0, W3_MARK};
          nxt_steps[0].data[W3_POLL_BIT] = 1'b1; // R07
          nxt_steps[1] = {1'b1, 1'b0, 8'h00}; // R05
          nxt_is_poll = 1'b1;
          n = 3'd2;
        end
        OP_RD_REQ, OP_RD_INSVC: begin
          // Skip the select write when the device already points there
          if (!sel_ok_ff || sel_isr_ff != (op == OP_RD_INSVC)) begin
            nxt_steps[0] = {1'b0, 1'b0, W3_MARK};
            nxt_steps[0].data[W3_RDEN_BIT] = 1'b1; // R10
            nxt_steps[0].data[W3_RSEL_BIT] = (op == OP_RD_INSVC); // R11
            n = 3'd1;
          end
          nxt_steps[n[1:0]] = {1'b1, 1'b0, 8'h00}; // R13
          n = n + 3'd1;
          nxt_sel_ok = 1'b1;
          nxt_sel_isr = (op == OP_RD_INSVC);
        end
        OP_RD_MASK: begin
          nxt_steps[0] = {1'b1, 1'b1, 8'h00}; // R12
          n = 3'd1;
        end
        default: n = 3'd0;
      endcase
      nxt_num = n;
      nxt_idx = 2'd0;
      nxt_sq = (n == 3'd0) ? SQ_IDLE : SQ_ISSUE;
    end
    // Walk the queued accesses one bus cycle at a time
    case (sq_ff)
      SQ_IDLE: begin
      end
      SQ_ISSUE: begin
        cy_start = 1'b1;
        nxt_sq = SQ_WAIT;
      end
      SQ_WAIT: begin
        if (cy_done) begin
          if (steps_ff[idx_ff].rd) begin
            nxt_result = cy_rdata;
            if (is_poll_ff) begin
              nxt_poll_hit = cy_rdata[POLL_ANY_BIT]; // R08
            end
          end
          nxt_sq = SQ_NEXT;
        end
      end
      SQ_NEXT: begin
        if ({1'b0, idx_ff} + 3'd1 >= num_ff) begin
          nxt_sq = SQ_IDLE;
        end else begin
          nxt_idx = idx_ff + 2'd1;
          nxt_sq = SQ_ISSUE;
        end
      end
      default: nxt_sq = SQ_IDLE;
    endcase
  end

  // Sequencer and register state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sq_ff <= SQ_IDLE;
      for (int i = 0; i < 4; i++) begin
        steps_ff[i] <= '0;
      end
      num_ff <= 3'd0;
      idx_ff <= 2'd0;
      init_ff <= INIT_RESET;
      mask_ff <= MASK_RESET;
      result_ff <= 8'h00;
      inited_ff <= 1'b0;
      spmask_ff <= 1'b0;
      sel_ok_ff <= 1'b0;
      sel_isr_ff <= 1'b0;
      is_poll_ff <= 1'b0;
      poll_hit_ff <= 1'b0;
    end else if (ce) begin
      sq_ff <= nxt_sq;
      steps_ff <= nxt_steps;
      num_ff <= nxt_num;
      idx_ff <= nxt_idx;
      init_ff <= nxt_init;
      mask_ff <= nxt_mask;
      result_ff <= nxt_result;
      inited_ff <= nxt_inited;
      spmask_ff <= nxt_spmask;
      sel_ok_ff <= nxt_sel_ok;
      sel_isr_ff <= nxt_sel_isr;
      is_poll_ff <= nxt_is_poll;
      poll_hit_ff <= nxt_poll_hit;
    end
  end

  // Read mux; data stand in the cycle after the strobe, unmapped reads zero
  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_rd) begin
      case (reg_addr)
        REG_STATUS: nxt_rdata = {26'h000_0000, poll_hit_ff, sel_ok_ff, spmask_ff, inited_ff,
          pin_sync[8], (sq_ff != SQ_IDLE)};
        REG_INIT: nxt_rdata = {7'h00, init_ff};
        REG_MASK: nxt_rdata = {24'h00_0000, mask_ff};
        REG_RESULT: nxt_rdata = {24'h00_0000, result_ff};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  // Interrupts held off for the whole command, not per bus cycle
  assign cpu_int_block = (sq_ff != SQ_IDLE); // R26
endmodule
`default_nettype wire

// ==== tb/pic_host_checker.sv ====
// Port-level checker for the interrupt-controller host driver
`timescale 1ns/1ps
`default_nettype none
module pic_host_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Software register port
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Device side
  input wire pic_pkg::pic_pins_t dev_pins,
  input wire logic [7:0] dev_data_i,
  input wire logic dev_int,
  input wire logic cpu_int_block
);
  import pic_pkg::*;
  // One clock domain, so one default clocking and reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_strobe_in_cs: assert property ((!dev_pins.rd_n || !dev_pins.wr_n) |-> !dev_pins.cs_n)
    else $error("strobe outside chip select");
  a_single_strobe: assert property (!(!dev_pins.rd_n && !dev_pins.wr_n))
    else $error("read and write strobes together");
  a_write_len: assert property ($fell(dev_pins.wr_n) |-> !dev_pins.wr_n [*4] ##1 dev_pins.wr_n)
    else $error("write strobe not four cycles");
  a_read_len: assert property ($fell(dev_pins.rd_n) |-> !dev_pins.rd_n [*4] ##1 dev_pins.rd_n)
    else $error("read strobe not four cycles");
  a_cs_setup: assert property ($fell(dev_pins.cs_n) |-> (dev_pins.rd_n && dev_pins.wr_n) ##1
    (!dev_pins.rd_n || !dev_pins.wr_n))
    else $error("strobe without one setup cycle");
  a_cs_length: assert property ($fell(dev_pins.cs_n) |-> !dev_pins.cs_n [*6] ##1 dev_pins.cs_n)
    else $error("chip select not six cycles");
  a_bus_steady: assert property ((!dev_pins.cs_n && !$past(dev_pins.cs_n)) |->
    $stable(dev_pins.command_select_line) && $stable(dev_pins.data_o))
    else $error("address or data moved in a cycle");
  a_drive_on_write: assert property (!dev_pins.wr_n |-> dev_pins.data_oe)
    else $error("write without driving data");
  a_float_on_read: assert property (!dev_pins.rd_n |-> !dev_pins.data_oe)
    else $error("host drives bus during read");
  a_irq_held_off: assert property (!dev_pins.cs_n |-> cpu_int_block)
    else $error("device access with processor interrupts open");
  a_unmapped_zero: assert property ((reg_rd && reg_addr > REG_RESULT) |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  // Main scenarios
  c_read_cycle: cover property ($fell(dev_pins.rd_n));
  c_write_cycle: cover property ($fell(dev_pins.wr_n));
  c_unmapped: cover property (reg_rd && reg_addr > REG_RESULT);
endmodule
bind pic_host pic_host_checker u_chk (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dev_pins(dev_pins),
  .dev_data_i(dev_data_i), .dev_int(dev_int), .cpu_int_block(cpu_int_block));
`default_nettype wire

// ==== tb/pic_dev_model.sv ====
// Behavioural model of the eight-level interrupt controller on its strobed bus
`timescale 1ns/1ps
`default_nettype none
module pic_dev_model (
  // Pins from the host
  input wire pic_pkg::pic_pins_t pins,
  // Request lines from the bench
  input wire logic [7:0] req,
  // Toward the host
  output logic [7:0] data,
  output logic int_out
);
  import pic_pkg::*;
  // Device registers and init capture
  logic [7:0] pend_ff = 8'h00, insvc_ff = 8'h00, mask_ff = 8'h00, dout_ff = 8'h00, last_ff = 8'h00;
  logic [7:0] w1_ff = 8'h00, w2_ff = 8'h00, w3_ff = 8'h00, w4_ff = 8'h00;
  logic spmask_ff = 1'b0, sel_ff = 1'b0, poll_ff = 1'b0;
  logic [1:0] left_ff = 2'h0, step_ff = 2'h0;
  int writes = 0;
  int lvl;
  // Level to acknowledge; fixed priority, level 0 highest (rotation not modelled)
  function automatic int pick();
    for (int i = 0; i < 8; i++) begin
      if (pend_ff[i] && !mask_ff[i]) begin
        if (!spmask_ff && |(insvc_ff & ((8'h02 << i) - 8'h01))) return -1;
        return i;
      end
    end
    return -1;
  endfunction
  // Requests are latched whatever the mask says
  always @(req) pend_ff = pend_ff | req;
  // Words are taken at the end of the write strobe, while data is still driven
  always @(posedge pins.wr_n) begin
    if (!pins.cs_n) begin
      writes++;
      last_ff = pins.data_o;
      if (!pins.command_select_line && pins.data_o[4]) begin
        w1_ff = pins.data_o;
        left_ff = 2'h1 + {1'b0, !pins.data_o[1]} + {1'b0, pins.data_o[0]};
        step_ff = 2'h0;
        mask_ff = 8'h00;
        spmask_ff = 1'b0;
      end else if (pins.command_select_line && left_ff != 2'h0) begin
        if (step_ff == 2'h0) w2_ff = pins.data_o;
        else if (left_ff == 2'h1 && w1_ff[0]) w4_ff = pins.data_o;
        else w3_ff = pins.data_o;
        step_ff++;
        left_ff--;
      end else if (pins.command_select_line) begin
        mask_ff = pins.data_o;
      end else if (!pins.data_o[3]) begin
        lvl = -1;
        for (int i = 7; i >= 0; i--) if (insvc_ff[i]) lvl = i;
        if (pins.data_o[6:5] == 2'h3) insvc_ff[pins.data_o[2:0]] = 1'b0;
        else if (pins.data_o[5] && lvl >= 0) insvc_ff[lvl] = 1'b0;
      end else begin
        if (pins.data_o[6]) spmask_ff = pins.data_o[5];
        if (pins.data_o[1]) sel_ff = pins.data_o[0];
        poll_ff = pins.data_o[2];
      end
    end
  end
  // Read answer chosen as the strobe falls
  always @(negedge pins.rd_n) begin
    if (!pins.cs_n) begin
      if (poll_ff) begin
        lvl = pick();
        dout_ff = (lvl < 0) ? 8'h00 : {5'h10, 3'(lvl)};
        if (lvl >= 0) begin
          insvc_ff[lvl] = 1'b1;
          pend_ff[lvl] = 1'b0;
        end
      end else if (pins.command_select_line) begin
        dout_ff = mask_ff;
      end else begin
        dout_ff = sel_ff ? insvc_ff : pend_ff;
      end
      poll_ff = 1'b0;
    end
  end
  // Released bus shows the inverse, so stale data never looks valid
  assign data = (!pins.cs_n && !pins.rd_n) ? dout_ff : ~dout_ff;
  assign int_out = |(pend_ff & ~mask_ff);
endmodule
`default_nettype wire

// ==== tb/pic_host_bench.sv ====
// Self-checking bench for the interrupt-controller host driver
`timescale 1ns/1ps
`default_nettype none
module pic_host_bench;
  import pic_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, dev_int, cpu_int_block;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
  logic [7:0] dev_data_i, req = 8'h00;
  pic_pins_t dev_pins;
  int fails = 0, checks_done = 0;
  always #50 clk = ~clk;
  pic_host u_dut (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dev_pins(dev_pins),
    .dev_data_i(dev_data_i), .dev_int(dev_int), .cpu_int_block(cpu_int_block));
  pic_dev_model u_dev (.pins(dev_pins), .req(req), .data(dev_data_i), .int_out(dev_int));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // One-cycle register write and read
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // Issue a command and wait, bounded, until busy drops
  task automatic cmd(input logic [3:0] op, input logic [2:0] lvl);
    int n;
    wr(REG_CMD, {25'h0, lvl, op});
    for (n = 0; n < 200; n++) begin
      rd(REG_STATUS, rv);
      if (n > 0 && rv[0] === 1'b0) break;
    end
    if (n == 200) begin
      fails++;
      finish_test();
    end
  endtask
  task automatic t_reset();
    rd(REG_INIT, rv);
    chk(rv, 32'(INIT_RESET));
    rd(REG_MASK, rv);
    chk(rv, 32'(MASK_RESET));
    rd(5'h14, rv);
    chk(rv, 32'h0);
    chk(32'(dev_pins.cs_n), 32'h1);
    $display("test reset done");
  endtask
  task automatic t_init();
    // Cascaded, interval four, no word four: word three must follow word two
    wr(REG_INIT, 32'h0000_5344);
    cmd(OP_INIT, 3'h0);
    chk(32'(u_dev.w1_ff), 32'h5C);
    chk(32'(u_dev.w2_ff), 32'h44);
    chk(32'(u_dev.w3_ff), 32'h05);
    rd(REG_STATUS, rv);
    chk(32'(rv[2]), 32'h1);
    wr(REG_INIT, 32'h0030_0D48);
    rd(REG_INIT, rv);
    chk(rv, 32'h0030_0D48);
    cmd(OP_INIT, 3'h0);
    chk(32'(u_dev.w1_ff), 32'h5B);
    chk(32'(u_dev.w2_ff), 32'h48);
    chk(32'(u_dev.w4_ff), 32'h03);
    $display("test init done");
  endtask
  task automatic t_mask();
    int n;
    wr(REG_MASK, 32'hA5);
    cmd(OP_MASK_WR, 3'h0);
    chk(32'(u_dev.mask_ff), 32'hA5);
    n = u_dev.writes;
    cmd(OP_RD_MASK, 3'h0);
    rd(REG_RESULT, rv);
    chk(rv[7:0], 32'hA5);
    chk(u_dev.writes, n);
    $display("test mask done");
  endtask
  task automatic t_words();
    logic [7:0] exp [0:8];
    exp = '{8'h20, 8'h65, 8'hA0, 8'hE5, 8'hC5, 8'h80, 8'h00, 8'h68, 8'h48};
    for (int i = 0; i < 9; i++) begin
      cmd(4'(i + 2), 3'h5);
      chk(32'(u_dev.last_ff), 32'(exp[i]));
      rd(REG_STATUS, rv);
      chk(32'(rv[3]), (i == 7) ? 32'h1 : 32'h0);
    end
    $display("test words done");
  endtask
  task automatic t_poll();
    int n;
    req <= 8'h28;
    @(posedge clk);
    req <= 8'h00;
    wr(REG_MASK, 32'h08);
    cmd(OP_MASK_WR, 3'h0);
    rd(REG_STATUS, rv);
    chk(32'(rv[1]), 32'h1);
    cmd(OP_POLL, 3'h0);
    rd(REG_RESULT, rv);
    chk(rv[7:0], 32'h85);
    chk(32'(u_dev.pend_ff), 32'h08);
    rd(REG_STATUS, rv);
    chk(32'(rv[5]), 32'h1);
    cmd(OP_RD_INSVC, 3'h0);
    rd(REG_RESULT, rv);
    chk(rv[7:0], 32'h20);
    cmd(OP_RD_REQ, 3'h0);
    n = u_dev.writes;
    cmd(OP_RD_REQ, 3'h0);
    rd(REG_RESULT, rv);
    chk(rv[7:0], 32'h08);
    chk(u_dev.writes, n);
    wr(REG_MASK, 32'h00);
    cmd(OP_MASK_WR, 3'h0);
    cmd(OP_POLL, 3'h0);
    rd(REG_RESULT, rv);
    chk(rv[7:0], 32'h83);
    cmd(OP_EOI, 3'h0);
    chk(32'(u_dev.insvc_ff), 32'h20);
    cmd(OP_EOI_SPEC, 3'h5);
    cmd(OP_RD_INSVC, 3'h0);
    rd(REG_RESULT, rv);
    chk(rv[7:0], 32'h00);
    cmd(OP_POLL, 3'h0);
    rd(REG_RESULT, rv);
    chk(32'(rv[7]), 32'h0);
    chk(32'(u_dev.insvc_ff), 32'h00);
    rd(REG_STATUS, rv);
    chk(32'(rv[5]), 32'h0);
    chk(32'(rv[1]), 32'h0);
    $display("test poll done");
  endtask
  // Clock enable low drops a write; a mid-run reset clears all host state
  task automatic t_ctrl();
    ce <= 1'b0;
    wr(REG_MASK, 32'h5A);
    ce <= 1'b1;
    rd(REG_MASK, rv);
    chk(rv, 32'h00);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd(REG_INIT, rv);
    chk(rv, 32'(INIT_RESET));
    rd(REG_STATUS, rv);
    chk(rv, 32'h0);
    $display("test control done");
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_init();
    t_mask();
    t_words();
    t_poll();
    t_ctrl();
    finish_test();
  end
  // Hang guard
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
